// ===== rtl/dltc_pin_sync.sv
// Two-flop pin synchroniser with falling edge detect per bit
`timescale 1ns/10ps
module dltc_pin_sync #(
	parameter int W = dltc_pkg::PIN_COUNT
) (
	input  wire logic         mclk_in,
	input  wire logic         sys_rst_in,
	input  wire logic [W-1:0] pins_in,
	output logic      [W-1:0] level_out,
	output logic      [W-1:0] fall_out
);

	dltc_pkg::dltc_sync_t q;
	dltc_pkg::dltc_sync_t d;

	always_comb begin
		d    = q;
		d.s1 = pins_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			q <= '1;
		end else begin
			q <= d;
		end
	end

	assign level_out = q.s2;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_fall
			// High sample then low sample
			assign fall_out[i] = q.s3[i] & ~q.s2[i];
		end
	endgenerate

endmodule // dltc_pin_sync

// ===== rtl/dltc_pkg.sv
// Constants and types shared by the dual timer/counter block
package dltc_pkg;

	// Register addresses on the special function register bus
	localparam logic [7:0] ADDR_CTRL     = 8'h88;
	localparam logic [7:0] ADDR_MODE     = 8'h89;
	localparam logic [7:0] ADDR_T0_LO    = 8'h8A;
	localparam logic [7:0] ADDR_T1_LO    = 8'h8B;
	localparam logic [7:0] ADDR_T0_HI    = 8'h8C;
	localparam logic [7:0] ADDR_T1_HI    = 8'h8D;
	localparam logic [7:0] ADDR_PRESCALE = 8'h8E;

	// Reset values
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] MODE_RESET  = 8'h00;
	localparam logic [7:0] COUNT_RESET = 8'h00;
	localparam logic [1:0] PRE_RESET   = 2'h0;
	localparam logic [7:0] READ_ZERO   = 8'h00;

	// timer_control_status fields
	localparam int CTRL_TF1 = 7;
	localparam int CTRL_TR1 = 6;
	localparam int CTRL_TF0 = 5;
	localparam int CTRL_TR0 = 4;
	localparam int CTRL_IE1 = 3;
	localparam int CTRL_IT1 = 2;
	localparam int CTRL_IE0 = 1;
	localparam int CTRL_IT0 = 0;

	// timer_mode_select fields
	localparam int MODE_SECOND_GATE_BIT = 7;
	localparam int MODE_CT1   = 6;
	localparam int MODE_M1_HI = 5;
	localparam int MODE_M1_LO = 4;
	localparam int MODE_FIRST_GATE_BIT = 3;
	localparam int MODE_CT0   = 2;
	localparam int MODE_M0_HI = 1;
	localparam int MODE_M0_LO = 0;

	// clock_prescale_control fields (only these two bits are held)
	localparam int PRE_T1_POS = 4;
	localparam int PRE_T0_POS = 3;

	// Pin indices into the synchroniser vector
	localparam int PIN_CNT0  = 0;
	localparam int PIN_CNT1  = 1;
	localparam int PIN_IRQ_A = 2;
	localparam int PIN_IRQ_B = 3;
	localparam int PIN_COUNT = 4;

	// Vector acknowledge indices
	localparam int ACK_TF0 = 0;
	localparam int ACK_TF1 = 1;
	localparam int ACK_IE0 = 2;
	localparam int ACK_IE1 = 3;

	// Prescale: one tick every twelve system clocks
	localparam int         PRESCALE_DIV = 12;
	localparam logic [3:0] DIV_LAST     = 4'(PRESCALE_DIV - 1);
	localparam logic [3:0] DIV_ONE      = 4'h1;

	// Count limits
	localparam logic [12:0] LIMIT_13 = 13'h1FFF;
	localparam logic [7:0]  LIMIT_8  = 8'hFF;

	typedef enum logic [1:0] {
		MODE_13      = 2'h0,
		MODE_16      = 2'h1,
		MODE_RELOAD8 = 2'h2,
		MODE_SPLIT   = 2'h3
	} dltc_mode_t;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] mode;
		logic [1:0] pre;
		logic [7:0] t0_lo;
		logic [7:0] t0_hi;
		logic [7:0] t1_lo;
		logic [7:0] t1_hi;
		logic [3:0] div;
		logic [7:0] rdata;
		logic       baud;
	} dltc_state_t;

	typedef struct packed {
		logic [PIN_COUNT-1:0] s1;
		logic [PIN_COUNT-1:0] s2;
		logic [PIN_COUNT-1:0] s3;
	} dltc_sync_t;

endpackage

// ===== rtl/dltc_top.sv
// Dual legacy timer/counter with control, mode and prescale registers
// How it works
// - Each timer's two-bit mode field picks 13-bit, 16-bit or reload mode; mode 3 splits the first timer and stops the second.
// - 13-bit mode: high byte upper eight bits, low byte bits 4..0, carry from bit 4.
// - 13-bit wrap from all ones sets the overflow flag and request.
// - Source select picks prescaled tick or falling edges on the count pin.
// - Counts only with run set and gate clear or interrupt pin high, except the second timer and the first high byte (second run only) while split.
// - Setting run leaves the count untouched; counting resumes from it.
// - 16-bit mode counts all sixteen bits, flag set on wrap to zero.
// - Reload mode: low byte counts, reloads from high byte on wrap, flag set.
// - Split mode: first low byte is 8-bit, uses first timer's own controls.
// - Split mode: first high byte counts ticks under second run, sets second flag.
// - Second timer in mode 3 stops and holds its value.
// - While split, second timer ignores pin, never sets flag, still gives baud.
// - Overflow flags set by hardware, cleared by software or vector acknowledge.
// - Interrupt type bit chooses active-low level or falling edge detection.
// - Edge mode flag sets on fall, software clears, acknowledge clears.
// - Level mode flag follows the inverted pin level.
// - Prescale bit 1 ticks every clock, 0 every twelve clocks.
`timescale 1ns/10ps
module dltc_top (
	input  wire logic       mclk_in,
	input  wire logic       sys_rst_in,
	input  wire logic [7:0] sfr_addr_in,
	input  wire logic       sfr_wr_in,
	input  wire logic       sfr_rd_in,
	input  wire logic [7:0] sfr_wdata_in,
	input  wire logic       first_count_pin_in,
	input  wire logic       second_count_pin_in,
	input  wire logic       ext_irq_a_pin_n_in,
	input  wire logic       ext_irq_b_pin_n_in,
	input  wire logic [3:0] vector_ack_in,
	output logic      [7:0] sfr_rdata_out,
	output logic            first_overflow_irq_out,
	output logic            second_overflow_irq_out,
	output logic            ext_irq_a_out,
	output logic            ext_irq_b_out,
	output logic            baud_tick_out
);

	dltc_pkg::dltc_state_t q;
	dltc_pkg::dltc_state_t d;

	logic [dltc_pkg::PIN_COUNT-1:0] pin_lvl;
	logic [dltc_pkg::PIN_COUNT-1:0] pin_fall;

	dltc_pin_sync #(
		.W (dltc_pkg::PIN_COUNT)
	) u_sync (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.pins_in    ({ext_irq_b_pin_n_in, ext_irq_a_pin_n_in,
		              second_count_pin_in, first_count_pin_in}),
		.level_out  (pin_lvl),
		.fall_out   (pin_fall)
	);

	// One increment: returns {overflow, high, low}
	function automatic logic [16:0] dltc_step(input dltc_pkg::dltc_mode_t m,
			input logic [7:0] lo, input logic [7:0] hi);
		logic [12:0] c13;
		logic [16:0] c16;
		logic [8:0]  c8;
		c13 = 13'({hi, lo[4:0]}) + 13'h0001;
		c16 = {1'b0, hi, lo} + 17'h00001;
		c8  = {1'b0, lo} + 9'h001;
		unique case (m)
			dltc_pkg::MODE_13: begin
				dltc_step = {({hi, lo[4:0]} == dltc_pkg::LIMIT_13), c13[12:5],
				             lo[7:5], c13[4:0]};
			end
			dltc_pkg::MODE_16: begin
				dltc_step = c16;
			end
			dltc_pkg::MODE_RELOAD8: begin
				dltc_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
			end
			dltc_pkg::MODE_SPLIT: begin
				dltc_step = {c8[8], hi, c8[7:0]};
			end
		endcase
	endfunction

	dltc_pkg::dltc_mode_t m0;
	dltc_pkg::dltc_mode_t m1;
	logic        tick12;
	logic        tick0;
	logic        tick1;
	logic        split;
	logic        inc0;
	logic        inc1;
	logic        inc_hi;
	logic        set_tf0;
	logic        set_tf1;
	logic        ovf1;
	logic [16:0] n0;
	logic [16:0] n1;
	logic        wr_ctrl;
	logic        wr_mode;
	logic        wr_t0;
	logic        wr_t1;

	always_comb begin
		d       = q;
		m0      = dltc_pkg::dltc_mode_t'(q.mode[dltc_pkg::MODE_M0_HI:dltc_pkg::MODE_M0_LO]);
		m1      = dltc_pkg::dltc_mode_t'(q.mode[dltc_pkg::MODE_M1_HI:dltc_pkg::MODE_M1_LO]);
		wr_ctrl = sfr_wr_in && (sfr_addr_in == dltc_pkg::ADDR_CTRL);
		wr_mode = sfr_wr_in && (sfr_addr_in == dltc_pkg::ADDR_MODE);
		wr_t0   = sfr_wr_in && (sfr_addr_in == dltc_pkg::ADDR_T0_LO
		                     || sfr_addr_in == dltc_pkg::ADDR_T0_HI);
		wr_t1   = sfr_wr_in && (sfr_addr_in == dltc_pkg::ADDR_T1_LO
		                     || sfr_addr_in == dltc_pkg::ADDR_T1_HI);

		// Free-running divide by twelve
		tick12 = (q.div == dltc_pkg::DIV_LAST);
		d.div  = tick12 ? '0 : q.div + dltc_pkg::DIV_ONE;
		tick0  = q.pre[0] | tick12;
		tick1  = q.pre[1] | tick12;

		split = (m0 == dltc_pkg::MODE_SPLIT);

		// First timer (whole, or low byte when split)
		inc0 = q.ctrl[dltc_pkg::CTRL_TR0]
		     & (~q.mode[dltc_pkg::MODE_FIRST_GATE_BIT] | pin_lvl[dltc_pkg::PIN_IRQ_A])
		     & (q.mode[dltc_pkg::MODE_CT0] ? pin_fall[dltc_pkg::PIN_CNT0] : tick0);
		n0   = dltc_step(m0, q.t0_lo, q.t0_hi);

		// Split high byte: ticks only, gated by second run bit
		inc_hi = split & q.ctrl[dltc_pkg::CTRL_TR1] & tick0;

		// Second timer; while split it free-runs on ticks and mode 3 turns it off
		inc1 = (split ? 1'b1 : (q.ctrl[dltc_pkg::CTRL_TR1]
		       & (~q.mode[dltc_pkg::MODE_SECOND_GATE_BIT] | pin_lvl[dltc_pkg::PIN_IRQ_B])))
		     & ((q.mode[dltc_pkg::MODE_CT1] & ~split) ? pin_fall[dltc_pkg::PIN_CNT1]
		                                              : tick1)
		     & (m1 != dltc_pkg::MODE_SPLIT);
		n1   = dltc_step(m1, q.t1_lo, q.t1_hi);
		ovf1 = inc1 & n1[16];

		set_tf0 = inc0 & n0[16];
		set_tf1 = split ? (inc_hi & (q.t0_hi == dltc_pkg::LIMIT_8)) : ovf1;
		d.baud  = ovf1;

		// Counting never clears on run; registers only move by increment or write
		if (inc0) begin
			d.t0_lo = n0[7:0];
			if (!split) begin
				d.t0_hi = n0[15:8];
			end
		end
		if (inc_hi) begin
			d.t0_hi = q.t0_hi + 8'h01;
		end
		if (inc1) begin
			d.t1_lo = n1[7:0];
			d.t1_hi = n1[15:8];
		end

		// Software writes override a same-cycle increment
		if (sfr_wr_in) begin
			unique case (sfr_addr_in)
				dltc_pkg::ADDR_T0_LO: d.t0_lo = sfr_wdata_in;
				dltc_pkg::ADDR_T0_HI: d.t0_hi = sfr_wdata_in;
				dltc_pkg::ADDR_T1_LO: d.t1_lo = sfr_wdata_in;
				dltc_pkg::ADDR_T1_HI: d.t1_hi = sfr_wdata_in;
				dltc_pkg::ADDR_MODE:  d.mode  = sfr_wdata_in;
				dltc_pkg::ADDR_CTRL:  d.ctrl  = sfr_wdata_in;
				dltc_pkg::ADDR_PRESCALE: begin
					d.pre = {sfr_wdata_in[dltc_pkg::PRE_T1_POS],
					         sfr_wdata_in[dltc_pkg::PRE_T0_POS]};
				end
				default: d = d;
			endcase
		end

		// Vector acknowledge clears, then hardware sets win
		if (vector_ack_in[dltc_pkg::ACK_TF0]) begin
			d.ctrl[dltc_pkg::CTRL_TF0] = 1'b0;
		end
		if (vector_ack_in[dltc_pkg::ACK_TF1]) begin
			d.ctrl[dltc_pkg::CTRL_TF1] = 1'b0;
		end
		if (vector_ack_in[dltc_pkg::ACK_IE0] && d.ctrl[dltc_pkg::CTRL_IT0]) begin
			d.ctrl[dltc_pkg::CTRL_IE0] = 1'b0;
		end
		if (vector_ack_in[dltc_pkg::ACK_IE1] && d.ctrl[dltc_pkg::CTRL_IT1]) begin
			d.ctrl[dltc_pkg::CTRL_IE1] = 1'b0;
		end
		if (set_tf0) begin
			d.ctrl[dltc_pkg::CTRL_TF0] = 1'b1;
		end
		if (set_tf1) begin
			d.ctrl[dltc_pkg::CTRL_TF1] = 1'b1;
		end

		// External interrupt detectors
		if (d.ctrl[dltc_pkg::CTRL_IT0]) begin
			if (pin_fall[dltc_pkg::PIN_IRQ_A]) begin
				d.ctrl[dltc_pkg::CTRL_IE0] = 1'b1;
			end
		end else begin
			d.ctrl[dltc_pkg::CTRL_IE0] = ~pin_lvl[dltc_pkg::PIN_IRQ_A];
		end
		if (d.ctrl[dltc_pkg::CTRL_IT1]) begin
			if (pin_fall[dltc_pkg::PIN_IRQ_B]) begin
				d.ctrl[dltc_pkg::CTRL_IE1] = 1'b1;
			end
		end else begin
			d.ctrl[dltc_pkg::CTRL_IE1] = ~pin_lvl[dltc_pkg::PIN_IRQ_B];
		end

		// Registered read data; unmapped addresses read zero
		if (sfr_rd_in) begin
			unique case (sfr_addr_in)
				dltc_pkg::ADDR_CTRL:  d.rdata = q.ctrl;
				dltc_pkg::ADDR_MODE:  d.rdata = q.mode;
				dltc_pkg::ADDR_T0_LO: d.rdata = q.t0_lo;
				dltc_pkg::ADDR_T0_HI: d.rdata = q.t0_hi;
				dltc_pkg::ADDR_T1_LO: d.rdata = q.t1_lo;
				dltc_pkg::ADDR_T1_HI: d.rdata = q.t1_hi;
				dltc_pkg::ADDR_PRESCALE: begin
					d.rdata = {3'h0, q.pre, 3'h0};
				end
				default: d.rdata = dltc_pkg::READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			q.ctrl  <= dltc_pkg::CTRL_RESET;
			q.mode  <= dltc_pkg::MODE_RESET;
			q.pre   <= dltc_pkg::PRE_RESET;
			q.t0_lo <= dltc_pkg::COUNT_RESET;
			q.t0_hi <= dltc_pkg::COUNT_RESET;
			q.t1_lo <= dltc_pkg::COUNT_RESET;
			q.t1_hi <= dltc_pkg::COUNT_RESET;
			q.div   <= '0;
			q.rdata <= dltc_pkg::READ_ZERO;
			q.baud  <= 1'b0;
		end else begin
			q <= d;
		end
	end

	assign sfr_rdata_out           = q.rdata;
	assign first_overflow_irq_out  = q.ctrl[dltc_pkg::CTRL_TF0];
	assign second_overflow_irq_out = q.ctrl[dltc_pkg::CTRL_TF1];
	assign ext_irq_a_out           = q.ctrl[dltc_pkg::CTRL_IE0];
	assign ext_irq_b_out           = q.ctrl[dltc_pkg::CTRL_IE1];
	assign baud_tick_out           = q.baud;

	prescale_period_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		tick12 |-> ##12 tick12)
		else $error("prescale tick period is not twelve clocks");

	run_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(!q.ctrl[dltc_pkg::CTRL_TR0] && !split && !wr_t0)
		|=> ($stable(q.t0_lo) && $stable(q.t0_hi)))
		else $error("first timer moved with run clear");

	gate_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(q.mode[dltc_pkg::MODE_FIRST_GATE_BIT] && !pin_lvl[dltc_pkg::PIN_IRQ_A] && !wr_t0)
		|=> $stable(q.t0_lo))
		else $error("first timer counted with gate closed");

	wrap13_flag_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(m0 == dltc_pkg::MODE_13 && inc0 && {q.t0_hi, q.t0_lo[4:0]} == dltc_pkg::LIMIT_13
		 && !wr_t0 && !wr_ctrl)
		|=> (q.ctrl[dltc_pkg::CTRL_TF0] && q.t0_hi == 8'h00 && q.t0_lo[4:0] == 5'h00))
		else $error("13-bit wrap did not clear count and set flag");

	reload_copy_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(m0 == dltc_pkg::MODE_RELOAD8 && inc0 && q.t0_lo == dltc_pkg::LIMIT_8 && !wr_t0)
		|=> (q.t0_lo == $past(q.t0_hi) && $stable(q.t0_hi)))
		else $error("reload did not copy high byte into low byte");

	split_high_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(inc_hi && q.t0_hi == dltc_pkg::LIMIT_8 && !wr_ctrl)
		|=> q.ctrl[dltc_pkg::CTRL_TF1])
		else $error("split high byte overflow did not set second flag");

	second_hold_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(m1 == dltc_pkg::MODE_SPLIT && !wr_t1)[*2]
		|-> ($stable(q.t1_lo) && $stable(q.t1_hi)))
		else $error("second timer moved in mode 3");

	split_noflag_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(split && ovf1 && !inc_hi && !wr_ctrl && !q.ctrl[dltc_pkg::CTRL_TF1])
		|=> (!q.ctrl[dltc_pkg::CTRL_TF1] && baud_tick_out))
		else $error("second overflow set flag while split or gave no baud");

	edge_flag_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(q.ctrl[dltc_pkg::CTRL_IT0] && pin_fall[dltc_pkg::PIN_IRQ_A] && !wr_ctrl)
		|=> ext_irq_a_out)
		else $error("falling edge did not set interrupt flag");

	level_flag_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(!q.ctrl[dltc_pkg::CTRL_IT1] && !wr_ctrl)
		|=> (ext_irq_b_out == !$past(pin_lvl[dltc_pkg::PIN_IRQ_B])))
		else $error("level flag does not follow inverted pin");

	ack_clear_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		(vector_ack_in[dltc_pkg::ACK_TF0] && !set_tf0 && !wr_ctrl)
		|=> !first_overflow_irq_out)
		else $error("acknowledge did not clear first overflow flag");

	mode_write_a: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
		wr_mode |=> (q.mode == $past(sfr_wdata_in)))
		else $error("mode register did not take the written value");

endmodule // dltc_top

// ===== sim/dltc_irq_host.sv
// Interrupt logic model that vectors to pending requests and acknowledges them
`timescale 1ns/10ps
module dltc_irq_host (
	input  wire logic       mclk_in,
	input  wire logic       sys_rst_in,
	input  wire logic [3:0] en_in,
	input  wire logic [3:0] lat_in,
	input  wire logic [3:0] irq_in,
	output logic      [3:0] ack_out
);
	logic [3:0] cnt_q [4];

	always_ff @(posedge mclk_in) begin
		for (int i = 0; i < 4; i++) begin
			ack_out[i] <= 1'b0;
			if (sys_rst_in || !(irq_in[i] && en_in[i]) || ack_out[i]) begin
				cnt_q[i] <= 4'h0;
			end else if (cnt_q[i] >= lat_in) begin
				// Vector taken after the chosen latency
				ack_out[i] <= 1'b1;
				cnt_q[i]   <= 4'h0;
			end else begin
				cnt_q[i] <= cnt_q[i] + 4'h1;
			end
		end
	end
endmodule // dltc_irq_host

// ===== sim/dltc_top_tb_top.sv
// Self-checking testbench for the dual timer/counter block
`timescale 1ns/10ps
module dltc_top_tb_top;
	logic       mclk;
	logic       rst;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr_s;
	logic       rd_s;
	logic [3:0] pins;
	logic [3:0] ack_en;
	logic [3:0] lat;
	logic [3:0] ack;
	logic [7:0] rdata;
	logic [7:0] tmp_a;
	logic [7:0] tmp_b;
	wire  [3:0] irqv;
	wire        baud;
	int         error_cnt = 0;
	int         n_checks = 0;
	int         n;

	dltc_top DUT (
		.mclk_in(mclk), .sys_rst_in(rst), .sfr_addr_in(addr), .sfr_wr_in(wr_s),
		.sfr_rd_in(rd_s), .sfr_wdata_in(wdata), .first_count_pin_in(pins[0]),
		.second_count_pin_in(pins[1]), .ext_irq_a_pin_n_in(pins[2]),
		.ext_irq_b_pin_n_in(pins[3]), .vector_ack_in(ack), .sfr_rdata_out(rdata),
		.first_overflow_irq_out(irqv[0]), .second_overflow_irq_out(irqv[1]),
		.ext_irq_a_out(irqv[2]), .ext_irq_b_out(irqv[3]), .baud_tick_out(baud)
	);
	dltc_irq_host host (
		.mclk_in(mclk), .sys_rst_in(rst), .en_in(ack_en), .lat_in(lat),
		.irq_in(irqv), .ack_out(ack)
	);

	always #50 mclk = ~mclk;

	task automatic close_out();
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic chk1(input logic e, input logic g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1 addr = a;
		wdata = d;
		wr_s = 1'b1;
		@(posedge mclk);
		#1 wr_s = 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		#1 addr = a;
		rd_s = 1'b1;
		@(posedge mclk);
		#1 rd_s = 1'b0;
		d = rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		chk(e, d);
	endtask

	// Pin levels held three clocks
	task automatic setpin(input int k, input logic v);
		@(posedge mclk);
		#1 pins[k] = v;
		repeat (3) @(posedge mclk);
	endtask

	task automatic fall(input int k);
		setpin(k, 1'b0);
		setpin(k, 1'b1);
	endtask

	task automatic waitf(input int k, input logic v);
		for (int i = 0; i < 30 && irqv[k] !== v; i++) begin
			@(posedge mclk);
			#2;
		end
		chk1(v, irqv[k]);
	endtask

	// Cycles between two rises of the first overflow request
	task automatic period(output int p);
		logic prev;
		prev = 1'b1;
		for (int i = 0; i < 200 && !(irqv[0] === 1'b1 && prev === 1'b0); i++) begin
			prev = irqv[0];
			@(posedge mclk);
			#2;
		end
		prev = 1'b1;
		for (p = 1; p < 200; p++) begin
			@(posedge mclk);
			#2;
			if (irqv[0] === 1'b1 && prev === 1'b0) break;
			prev = irqv[0];
		end
	endtask

	task automatic t_regs();
		rchk(dltc_pkg::ADDR_CTRL, 8'h00);
		rchk(dltc_pkg::ADDR_MODE, 8'h00);
		wr(dltc_pkg::ADDR_MODE, 8'hA5);
		rchk(dltc_pkg::ADDR_MODE, 8'hA5);
		wr(8'h80, 8'hFF);
		rchk(8'h80, 8'h00);
		wr(dltc_pkg::ADDR_PRESCALE, 8'hFF);
		rchk(dltc_pkg::ADDR_PRESCALE, 8'h18);
	endtask

	task automatic t_16();
		wr(dltc_pkg::ADDR_T0_LO, 8'hFE);
		wr(dltc_pkg::ADDR_T0_HI, 8'hFF);
		wr(dltc_pkg::ADDR_MODE, 8'h05);
		wr(dltc_pkg::ADDR_CTRL, 8'h10);
		fall(0);
		rchk(dltc_pkg::ADDR_T0_LO, 8'hFF);
		fall(0);
		waitf(0, 1'b1);
		rchk(dltc_pkg::ADDR_T0_HI, 8'h00);
		wr(dltc_pkg::ADDR_CTRL, 8'h00);
		chk1(1'b0, irqv[0]);
		fall(0);
		rchk(dltc_pkg::ADDR_T0_LO, 8'h00);
		wr(dltc_pkg::ADDR_CTRL, 8'h10);
		fall(0);
		rchk(dltc_pkg::ADDR_T0_LO, 8'h01);
	endtask

	task automatic t_13();
		wr(dltc_pkg::ADDR_CTRL, 8'h00);
		wr(dltc_pkg::ADDR_T0_LO, 8'h1F);
		wr(dltc_pkg::ADDR_T0_HI, 8'hFE);
		wr(dltc_pkg::ADDR_MODE, 8'h04);
		wr(dltc_pkg::ADDR_CTRL, 8'h10);
		fall(0);
		rd(dltc_pkg::ADDR_T0_LO, tmp_a);
		chk(8'h00, tmp_a & 8'h1F);
		rchk(dltc_pkg::ADDR_T0_HI, 8'hFF);
		wr(dltc_pkg::ADDR_T0_LO, 8'h1F);
		fall(0);
		waitf(0, 1'b1);
		rchk(dltc_pkg::ADDR_T0_HI, 8'h00);
		ack_en = 4'h1;
		waitf(0, 1'b0);
		ack_en = 4'h0;
	endtask

	task automatic t_reload();
		wr(dltc_pkg::ADDR_CTRL, 8'h00);
		wr(dltc_pkg::ADDR_T0_LO, 8'hFF);
		wr(dltc_pkg::ADDR_T0_HI, 8'h80);
		wr(dltc_pkg::ADDR_MODE, 8'h06);
		wr(dltc_pkg::ADDR_CTRL, 8'h10);
		fall(0);
		waitf(0, 1'b1);
		rchk(dltc_pkg::ADDR_T0_LO, 8'h80);
		rchk(dltc_pkg::ADDR_T0_HI, 8'h80);
	endtask

	task automatic t_gate();
		wr(dltc_pkg::ADDR_CTRL, 8'h00);
		wr(dltc_pkg::ADDR_T0_LO, 8'h00);
		wr(dltc_pkg::ADDR_MODE, 8'h0D);
		wr(dltc_pkg::ADDR_CTRL, 8'h10);
		setpin(2, 1'b0);
		fall(0);
		rchk(dltc_pkg::ADDR_T0_LO, 8'h00);
		chk1(1'b1, irqv[2]);
		setpin(2, 1'b1);
		fall(0);
		rchk(dltc_pkg::ADDR_T0_LO, 8'h01);
		chk1(1'b0, irqv[2]);
	endtask

	task automatic t_pre();
		wr(dltc_pkg::ADDR_CTRL, 8'h00);
		wr(dltc_pkg::ADDR_MODE, 8'h02);
		wr(dltc_pkg::ADDR_T0_HI, 8'hFC);
		wr(dltc_pkg::ADDR_T0_LO, 8'hFC);
		wr(dltc_pkg::ADDR_PRESCALE, 8'h00);
		ack_en = 4'h1;
		wr(dltc_pkg::ADDR_CTRL, 8'h10);
		period(n);
		chk(8'h30, 8'(n));
		wr(dltc_pkg::ADDR_PRESCALE, 8'h08);
		period(n);
		chk(8'h04, 8'(n));
		wr(dltc_pkg::ADDR_CTRL, 8'h00);
		ack_en = 4'h0;
	endtask

	task automatic t_split();
		wr(dltc_pkg::ADDR_T1_LO, 8'hFF);
		wr(dltc_pkg::ADDR_T1_HI, 8'hFF);
		wr(dltc_pkg::ADDR_T0_LO, 8'hFF);
		wr(dltc_pkg::ADDR_T0_HI, 8'hFF);
		wr(dltc_pkg::ADDR_PRESCALE, 8'h18);
		wr(dltc_pkg::ADDR_MODE, 8'h17);
		for (int i = 0; i < 20 && baud !== 1'b1; i++) begin
			@(posedge mclk);
			#2;
		end
		chk1(1'b1, baud);
		chk1(1'b0, irqv[1]);
		wr(dltc_pkg::ADDR_CTRL, 8'h40);
		waitf(1, 1'b1);
		wr(dltc_pkg::ADDR_CTRL, 8'h10);
		fall(0);
		waitf(0, 1'b1);
		wr(dltc_pkg::ADDR_MODE, 8'h37);
		rd(dltc_pkg::ADDR_T1_LO, tmp_a);
		rd(dltc_pkg::ADDR_T1_LO, tmp_b);
		chk(tmp_a, tmp_b);
	endtask

	task automatic t_ext();
		wr(dltc_pkg::ADDR_CTRL, 8'h00);
		setpin(3, 1'b0);
		waitf(3, 1'b1);
		setpin(3, 1'b1);
		waitf(3, 1'b0);
		wr(dltc_pkg::ADDR_CTRL, 8'h04);
		fall(3);
		chk1(1'b1, irqv[3]);
		wr(dltc_pkg::ADDR_CTRL, 8'h04);
		waitf(3, 1'b0);
		ack_en = 4'h8;
		lat = 4'h5;
		setpin(3, 1'b0);
		waitf(3, 1'b1);
		waitf(3, 1'b0);
		setpin(3, 1'b1);
	endtask

	// Second timer on its own pin and gate, interrupt A in edge mode
	task automatic t_second();
		wr(dltc_pkg::ADDR_MODE, 8'hD0);
		ack_en = 4'h0;
		wr(dltc_pkg::ADDR_T1_LO, 8'hFF);
		wr(dltc_pkg::ADDR_T1_HI, 8'hFF);
		wr(dltc_pkg::ADDR_CTRL, 8'h41);
		fall(1);
		waitf(1, 1'b1);
		rchk(dltc_pkg::ADDR_T1_HI, 8'h00);
		ack_en = 4'h2;
		waitf(1, 1'b0);
		setpin(3, 1'b0);
		fall(1);
		rchk(dltc_pkg::ADDR_T1_LO, 8'h00);
		setpin(3, 1'b1);
		fall(1);
		rchk(dltc_pkg::ADDR_T1_LO, 8'h01);
		fall(2);
		chk1(1'b1, irqv[2]);
		#1 ack_en = 4'h4;
		waitf(2, 1'b0);
	endtask

	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr_s = 1'b0;
		rd_s = 1'b0;
		pins = 4'hF;
		ack_en = 4'h0;
		lat = 4'h0;
		repeat (4) @(posedge mclk);
		#1 rst = 1'b0;
		t_regs();
		t_16();
		t_13();
		t_reload();
		t_gate();
		t_pre();
		t_split();
		t_ext();
		t_second();
		close_out();
	end

	// Hang guard
	initial begin
		#5000000;
		error_cnt++;
		close_out();
	end
endmodule // dltc_top_tb_top
